// ---- design/dmacm_pkg.sv ----
// constants, register map and encodings for the dma master control block
// Functional notes
// - global register 16 bits, reset zero, held
// - reserved global bits read zero
// - priority field picks fixed orders or round-robin
// - address error sets flag, stops channels
// - address error flag cleared by read-then-zero
// - nmi sets flag always, stops all transfers
// - nmi flag: one ignored, read-then-zero clears
// - both flags cleared by reset
// - master enable and channel enable gate
// - master enable cleared terminates all transfers
// - transfer needs enables, no end/error flags
// - each request moves one unit, count minus one
// - count zero ends transfer, interrupt if enabled
// - error or nmi aborts running unit
// - auto mode requests internally when enabled
// - external request pin, level or falling edge
// - external encodings select dual or single mode
// - six module sources, not with 16-byte size
// - requester need not be data endpoint
// - round-robin moves finished channel to bottom
// - end flag only on full count completion
package dmacm_pkg;
	localparam int          NUM_CH          = 4;
	localparam logic [7:0]  ADDR_GLOBAL     = 8'h00;
	localparam logic [7:0]  ADDR_CTRL_BASE  = 8'h10;
	localparam logic [7:0]  ADDR_COUNT_BASE = 8'h14;
	localparam logic [7:0]  ADDR_CH_STRIDE  = 8'h08;
	localparam logic [15:0] GLOBAL_RESET    = 16'h0000;
	localparam logic [15:0] CTRL_RESET      = 16'h0000;
	localparam logic [15:0] COUNT_RESET     = 16'h0000;
	localparam logic [15:0] CTRL_MASK       = 16'h0f5f;
	localparam int          GOP_PRI_HI      = 9;
	localparam int          GOP_PRI_LO      = 8;
	localparam int          GOP_AE          = 2;
	localparam int          GOP_NMI         = 1;
	localparam int          GOP_ME          = 0;
	localparam int          CTRL_RS_HI      = 11;
	localparam int          CTRL_RS_LO      = 8;
	localparam int          CTRL_DS         = 6;
	localparam int          CTRL_TS_HI      = 4;
	localparam int          CTRL_TS_LO      = 3;
	localparam int          CTRL_IE         = 2;
	localparam int          CTRL_TE         = 1;
	localparam int          CTRL_DE         = 0;
	localparam logic [3:0]  RS_EXT_DUAL     = 4'h0;
	localparam logic [3:0]  RS_EXT_MEM2DEV  = 4'h2;
	localparam logic [3:0]  RS_EXT_DEV2MEM  = 4'h3;
	localparam logic [3:0]  RS_AUTO         = 4'h4;
	localparam logic [3:0]  RS_TX0          = 4'ha;
	localparam logic [3:0]  RS_RX0          = 4'hb;
	localparam logic [3:0]  RS_TX1          = 4'hc;
	localparam logic [3:0]  RS_RX1          = 4'hd;
	localparam logic [3:0]  RS_CONV         = 4'he;
	localparam logic [3:0]  RS_CMP          = 4'hf;
	localparam logic [1:0]  TS_16BYTE       = 2'h3;
	localparam logic [1:0]  PRI_0123        = 2'h0;
	localparam logic [1:0]  PRI_0231        = 2'h1;
	localparam logic [1:0]  PRI_2013        = 2'h2;
	localparam logic [1:0]  PRI_RR          = 2'h3;
	localparam logic [7:0]  ORDER_0123      = 8'he4;
	localparam logic [7:0]  ORDER_0231      = 8'h78;
	localparam logic [7:0]  ORDER_2013      = 8'hd2;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} dmacm_state_t;
endpackage

// ---- design/dmacm_top.sv ----
// dma master control: global register, channel gating, arbitration, unit sequencing
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dmacm_top (
	input  wire logic        clk,                        // 250 MHz system clock
	input  wire logic        rstn,                       // async reset, active low
	input  wire logic        ce,                         // clock enable, low freezes state
	input  wire logic [7:0]  addr,                       // register byte address
	input  wire logic [15:0] wdata,                      // register write data
	input  wire logic        wr,                         // write strobe
	input  wire logic        rd,                         // read strobe
	output logic      [15:0] rdata,                      // read data, cycle after rd
	input  wire logic        nmi_event,                  // nmi occurrence pulse
	input  wire logic        addr_error_event,           // controller address error pulse
	input  wire logic [1:0]  external_request_in_n,      // request pins ch0/ch1, low active
	input  wire logic [1:0]  receive_full_request,       // serial ports 0/1 receive full
	input  wire logic [1:0]  transmit_empty_request,     // serial ports 0/1 transmit empty
	input  wire logic        conversion_end_request,     // converter done
	input  wire logic        compare_match_request,      // compare match timer
	output logic             xfer_valid,                 // unit in progress
	output logic      [1:0]  xfer_chan,                  // channel of the unit
	output logic      [1:0]  xfer_size,                  // unit size code
	output logic      [3:0]  xfer_source,                // request source code of channel
	input  wire logic        xfer_done,                  // bus side finished the unit
	output logic             xfer_abort,                 // one-cycle pulse, unit aborted
	output logic      [1:0]  external_ack_out,           // ack for ch0/ch1 during unit
	output logic      [3:0]  transfer_end_interrupt      // per-channel end interrupt
);
	logic         rst_meta;
	logic         rst_n_s;
	logic [15:0]  gop;
	logic         ae_armed;
	logic         nmi_armed;
	logic [15:0]  ctrl [dmacm_pkg::NUM_CH];
	logic [15:0]  count [dmacm_pkg::NUM_CH];
	logic [3:0]   te_armed;
	logic [1:0]   prev_req_n;
	logic [1:0]   edge_pend;
	logic [7:0]   rr_order;
	dmacm_pkg::dmacm_state_t state;
	dmacm_pkg::dmacm_state_t next_state;

	// reset release through two flops; only the second is used anywhere
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n_s  <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n_s  <= rst_meta;
		end
	end

	// global field decode
	wire [1:0] pri  = gop[dmacm_pkg::GOP_PRI_HI:dmacm_pkg::GOP_PRI_LO];
	wire       ae   = gop[dmacm_pkg::GOP_AE];
	wire       nonmaskable_event_flag = gop[dmacm_pkg::GOP_NMI];
	wire       me   = gop[dmacm_pkg::GOP_ME];
	wire       hit_global = (addr == dmacm_pkg::ADDR_GLOBAL);
	wire       wr_global  = wr && hit_global;
	wire       rd_global  = rd && hit_global;

	// per-channel decode and request qualification
	logic [3:0]  hit_ctrl;
	logic [3:0]  hit_count;
	logic [3:0]  chan_req;
	logic [3:0]  chan_ok;
	logic [15:0] rd_mux [dmacm_pkg::NUM_CH];
	wire         any_fault = ae || nonmaskable_event_flag;
	genvar gi;
	generate
		for (gi = 0; gi < dmacm_pkg::NUM_CH; gi++) begin : g_ch
			localparam logic [7:0] OFS = 8'(gi * 8);
			wire [3:0] rs  = ctrl[gi][dmacm_pkg::CTRL_RS_HI:dmacm_pkg::CTRL_RS_LO];
			wire [1:0] ts  = ctrl[gi][dmacm_pkg::CTRL_TS_HI:dmacm_pkg::CTRL_TS_LO];
			wire       de  = ctrl[gi][dmacm_pkg::CTRL_DE];
			wire       te  = ctrl[gi][dmacm_pkg::CTRL_TE];
			wire       is_ext = (rs == dmacm_pkg::RS_EXT_DUAL) ||
				(rs == dmacm_pkg::RS_EXT_MEM2DEV) ||
				(rs == dmacm_pkg::RS_EXT_DEV2MEM);
			wire       is_mod = rs[3] && (rs[2] || rs[1]);
			logic      ext_req;
			logic      mod_req;
			assign hit_ctrl[gi]  = (addr == dmacm_pkg::ADDR_CTRL_BASE + OFS);
			assign hit_count[gi] = (addr == dmacm_pkg::ADDR_COUNT_BASE + OFS);
			// external pins exist only for channels 0 and 1
			if (gi < 2) begin : g_pin
				assign ext_req = ctrl[gi][dmacm_pkg::CTRL_DS] ? edge_pend[gi] :
					!external_request_in_n[gi];
			end else begin : g_nopin
				assign ext_req = 1'b0;
			end
			// module sources; a 16-byte size makes them never request
			always_comb begin
				case (rs)
					dmacm_pkg::RS_TX0:  mod_req = transmit_empty_request[0];
					dmacm_pkg::RS_RX0:  mod_req = receive_full_request[0];
					dmacm_pkg::RS_TX1:  mod_req = transmit_empty_request[1];
					dmacm_pkg::RS_RX1:  mod_req = receive_full_request[1];
					dmacm_pkg::RS_CONV: mod_req = conversion_end_request;
					dmacm_pkg::RS_CMP:  mod_req = compare_match_request;
					default:            mod_req = 1'b0;
				endcase
			end
			assign chan_ok[gi] = de && me && !te && !any_fault;
			assign chan_req[gi] = chan_ok[gi] && (
				(rs == dmacm_pkg::RS_AUTO) ||
				(is_ext && ext_req) ||
				(is_mod && (ts != dmacm_pkg::TS_16BYTE) && mod_req));
			assign rd_mux[gi] = hit_ctrl[gi] ? (ctrl[gi] & dmacm_pkg::CTRL_MASK) :
				(hit_count[gi] ? count[gi] : 16'h0000);
		end
	endgenerate

	// active order: fixed tables or the rotating round-robin order
	logic [7:0] order;
	always_comb begin
		case (pri)
			dmacm_pkg::PRI_0123: order = dmacm_pkg::ORDER_0123;
			dmacm_pkg::PRI_0231: order = dmacm_pkg::ORDER_0231;
			dmacm_pkg::PRI_2013: order = dmacm_pkg::ORDER_2013;
			default:             order = rr_order;
		endcase
	end

	// pick the highest requesting channel, walking from the bottom up
	logic       grant_any;
	logic [1:0] grant_ch;
	always_comb begin
		grant_any = 1'b0;
		grant_ch  = 2'h0;
		for (int k = 3; k >= 0; k--) begin
			if (chan_req[order[2*k +: 2]]) begin
				grant_any = 1'b1;
				grant_ch  = order[2*k +: 2];
			end
		end
	end

	// rotated order with the running channel moved to the bottom
	logic [7:0] rr_next;
	always_comb begin
		logic seen;
		seen    = 1'b0;
		rr_next = rr_order;
		for (int k = 0; k < 3; k++) begin
			if (rr_order[2*k +: 2] == xfer_chan) begin
				seen = 1'b1;
			end
			if (seen) begin
				rr_next[2*k +: 2] = rr_order[2*k+2 +: 2];
			end
		end
		rr_next[7:6] = xfer_chan;
	end

	// a running unit stops at once when its channel loses any enable or a fault appears
	wire busy     = (state == dmacm_pkg::ST_BUSY);
	wire run_ok   = chan_ok[xfer_chan];
	wire abort_now = busy && (!run_ok || addr_error_event || nmi_event);
	wire done_now  = busy && xfer_done && !abort_now;
	wire last_unit = (count[xfer_chan] == 16'h0001);

	always_comb begin
		next_state = state;
		case (state)
			dmacm_pkg::ST_IDLE: begin
				if (grant_any) begin
					next_state = dmacm_pkg::ST_BUSY;
				end
			end
			dmacm_pkg::ST_BUSY: begin
				if (abort_now || done_now) begin
					next_state = dmacm_pkg::ST_IDLE;
				end
			end
			default: next_state = dmacm_pkg::ST_IDLE;
		endcase
	end

	// flag updates: a hardware set in the same cycle beats a software clear
	wire ae_clr  = wr_global && ae_armed && !wdata[dmacm_pkg::GOP_AE];
	wire nmi_clr = wr_global && nmi_armed && !wdata[dmacm_pkg::GOP_NMI];
	wire next_ae  = addr_error_event || (ae && !ae_clr);
	wire next_nmi = nmi_event || (nonmaskable_event_flag && !nmi_clr);

	// end flag set by the last unit, cleared by read-then-zero; kept as wires, not process temps
	wire [3:0] te_set_v = {4{done_now && last_unit}} & (4'h1 << xfer_chan);
	wire [3:0] te_clr_v = {4{wr && !wdata[dmacm_pkg::CTRL_TE]}} & hit_ctrl & te_armed;

	// global register; only priority and master enable are software-written
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			gop       <= dmacm_pkg::GLOBAL_RESET;
			ae_armed  <= 1'b0;
			nmi_armed <= 1'b0;
		end else if (ce) begin
			if (wr_global) begin
				gop[dmacm_pkg::GOP_PRI_HI:dmacm_pkg::GOP_PRI_LO] <=
					wdata[dmacm_pkg::GOP_PRI_HI:dmacm_pkg::GOP_PRI_LO];
				gop[dmacm_pkg::GOP_ME] <= wdata[dmacm_pkg::GOP_ME];
			end
			gop[dmacm_pkg::GOP_AE]  <= next_ae;
			gop[dmacm_pkg::GOP_NMI] <= next_nmi;
			// arming is lost when the flag drops, so a stale read cannot clear a new event
			ae_armed  <= next_ae && (ae_armed || (rd_global && ae)) && !ae_clr;
			nmi_armed <= next_nmi && (nmi_armed || (rd_global && nonmaskable_event_flag)) && !nmi_clr;
		end
	end

	// channel control and count registers
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			for (int i = 0; i < dmacm_pkg::NUM_CH; i++) begin
				ctrl[i]  <= dmacm_pkg::CTRL_RESET;
				count[i] <= dmacm_pkg::COUNT_RESET;
			end
			te_armed <= 4'h0;
		end else if (ce) begin
			for (int i = 0; i < dmacm_pkg::NUM_CH; i++) begin
				if (wr && hit_ctrl[i]) begin
					ctrl[i] <= (wdata & dmacm_pkg::CTRL_MASK) &
						~(16'h0001 << dmacm_pkg::CTRL_TE) |
						({15'h0000, ctrl[i][dmacm_pkg::CTRL_TE]} << dmacm_pkg::CTRL_TE);
				end
				ctrl[i][dmacm_pkg::CTRL_TE] <= te_set_v[i] ||
					(ctrl[i][dmacm_pkg::CTRL_TE] && !te_clr_v[i]);
				te_armed[i] <= !te_set_v[i] && !te_clr_v[i] && ctrl[i][dmacm_pkg::CTRL_TE] &&
					(te_armed[i] || (rd && hit_ctrl[i]));
				// software load wins over the decrement of the same cycle
				if (wr && hit_count[i]) begin
					count[i] <= wdata;
				end else if (done_now && (xfer_chan == 2'(i))) begin
					count[i] <= count[i] - 16'h0001;
				end
			end
		end
	end

	// edge capture for falling-edge detection, consumed by the grant
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			prev_req_n <= 2'h3;
			edge_pend  <= 2'h0;
		end else if (ce) begin
			prev_req_n <= external_request_in_n;
			for (int i = 0; i < 2; i++) begin
				edge_pend[i] <= (prev_req_n[i] && !external_request_in_n[i]) ||
					(edge_pend[i] && !(!busy && grant_any && grant_ch == 2'(i)));
			end
		end
	end

	// sequencer and unit outputs
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state       <= dmacm_pkg::ST_IDLE;
			xfer_valid  <= 1'b0;
			xfer_chan   <= 2'h0;
			xfer_size   <= 2'h0;
			xfer_source <= 4'h0;
			xfer_abort  <= 1'b0;
			external_ack_out <= 2'h0;
			rr_order    <= dmacm_pkg::ORDER_0123;
		end else if (ce) begin
			state      <= next_state;
			xfer_abort <= abort_now;
			if (!busy && grant_any) begin
				xfer_valid  <= 1'b1;
				xfer_chan   <= grant_ch;
				xfer_size   <= ctrl[grant_ch][dmacm_pkg::CTRL_TS_HI:dmacm_pkg::CTRL_TS_LO];
				xfer_source <= ctrl[grant_ch][dmacm_pkg::CTRL_RS_HI:dmacm_pkg::CTRL_RS_LO];
				external_ack_out <= (grant_ch[1] || ctrl[grant_ch][11:10] != 2'h0) ? 2'h0 :
					(2'h1 << grant_ch[0]);
			end else if (abort_now || done_now) begin
				xfer_valid       <= 1'b0;
				external_ack_out <= 2'h0;
			end
			if (done_now) begin
				rr_order <= rr_next;
			end
		end
	end

	// interrupt lines and read data, both registered
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			transfer_end_interrupt <= 4'h0;
			rdata <= 16'h0000;
		end else if (ce) begin
			for (int i = 0; i < dmacm_pkg::NUM_CH; i++) begin
				transfer_end_interrupt[i] <= ctrl[i][dmacm_pkg::CTRL_TE] &&
					ctrl[i][dmacm_pkg::CTRL_IE];
			end
			if (rd) begin
				rdata <= hit_global ? (gop & 16'h0307) :
					(rd_mux[0] | rd_mux[1] | rd_mux[2] | rd_mux[3]);
			end else begin
				rdata <= 16'h0000;
			end
		end
	end
endmodule // dmacm_top
`default_nettype wire

// ---- dv/dmacm_bus_model.sv ----
// bus side model: finishes each unit after a chosen number of cycles
`timescale 1ns/1ps
`default_nettype none
module dmacm_bus_model (
	input  wire logic       clk,         // system clock
	input  wire logic       xfer_valid,  // unit running
	input  wire logic [3:0] wait_cycles, // cycles before done
	output var  logic       xfer_done    // unit finished pulse
);
	logic [3:0] cnt = 4'h0;
	logic       sent = 1'b0;
	// one done per unit; held off until the unit drops so a slow drop is not answered twice
	always @(posedge clk) begin
		xfer_done <= 1'b0;
		if (!xfer_valid) begin
			cnt <= 4'h0;
			sent <= 1'b0;
		end else if (!sent && cnt == wait_cycles) begin
			xfer_done <= 1'b1;
			sent <= 1'b1;
		end else if (!sent) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule // dmacm_bus_model
`default_nettype wire

// ---- dv/dmacm_checker_sva.sv ----
// port-level assertions for the dma master control block
`timescale 1ns/1ps
`default_nettype none
module dmacm_checker (
	input wire logic        clk,              // clock
	input wire logic        rstn,             // reset, low
	input wire logic        ce,               // clock enable
	input wire logic [7:0]  addr,             // address
	input wire logic        rd,               // read strobe
	input wire logic [15:0] rdata,            // read data
	input wire logic        nmi_event,        // nmi pulse
	input wire logic        addr_error_event, // error pulse
	input wire logic        xfer_valid,       // unit running
	input wire logic [1:0]  xfer_chan,        // unit channel
	input wire logic [1:0]  xfer_size,        // unit size
	input wire logic [3:0]  xfer_source,      // unit source
	input wire logic        xfer_done,        // unit done
	input wire logic        xfer_abort,       // abort pulse
	input wire logic [1:0]  external_ack_out  // acknowledges
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// abort, then quiet: the raised flag blocks a regrant until software clears it
	sequence s_abort_quiet;
		xfer_abort && !xfer_valid ##1 !xfer_valid [*2];
	endsequence
	property p_nmi_abort;
		ce && xfer_valid && nmi_event |=> s_abort_quiet;
	endproperty
	property p_ae_abort;
		ce && xfer_valid && addr_error_event |=> s_abort_quiet;
	endproperty
	property p_abort_once;
		xfer_abort |-> $past(xfer_valid) ##1 !xfer_abort;
	endproperty
	property p_done_drop;
		ce && xfer_valid && xfer_done |=> !xfer_valid;
	endproperty
	property p_unit_hold;
		xfer_valid ##1 xfer_valid |-> $stable({xfer_chan, xfer_size, xfer_source});
	endproperty
	property p_ack_chan;
		external_ack_out != 2'h0 |-> xfer_valid && external_ack_out == 2'h1 << xfer_chan;
	endproperty
	property p_reserved_zero;
		ce && rd && addr == 8'h00 |=> rdata[15:10] == 6'h00 && rdata[7:3] == 5'h00;
	endproperty
	property p_module_size;
		xfer_valid && xfer_source >= 4'ha |-> xfer_size != 2'h3;
	endproperty
	a_nmi_abort: assert property (p_nmi_abort) else $error("nmi left unit running");
	a_ae_abort: assert property (p_ae_abort) else $error("error left unit running");
	a_abort_once: assert property (p_abort_once) else $error("bad abort pulse");
	a_done_drop: assert property (p_done_drop) else $error("unit outlived done");
	a_unit_hold: assert property (p_unit_hold) else $error("unit fields moved");
	a_ack_chan: assert property (p_ack_chan) else $error("ack on wrong channel");
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
	a_module_size: assert property (p_module_size) else $error("module unit 16-byte");
endmodule // dmacm_checker
`default_nettype wire

// ---- dv/tb_dma_channel_master_control.sv ----
// self-checking bench for the dma master control block
`timescale 1ns/1ps
`default_nettype none
bind dmacm_top dmacm_checker u_chk (.clk, .rstn, .ce, .addr, .rd, .rdata, .nmi_event,
	.addr_error_event, .xfer_valid, .xfer_chan, .xfer_size, .xfer_source, .xfer_done,
	.xfer_abort, .external_ack_out);
module tb_dma_channel_master_control;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        nmi_event = 1'b0;
	logic        addr_error_event = 1'b0;
	logic [1:0]  external_request_in_n = 2'h3;
	logic [3:0]  wait_cycles = 4'h0;
	logic [15:0] rdata;
	logic        xfer_valid;
	logic        xfer_done;
	logic        xfer_abort;
	logic [1:0]  xfer_chan;
	logic [1:0]  external_ack_out;
	logic [3:0]  transfer_end_interrupt;
	logic [3:0]  xfer_source;
	logic        ce = 1'b1;
	logic        conv_req = 1'b0;
	logic        prev_valid = 1'b0;
	logic [15:0] order = 16'h0000;
	int          n_errors = 0;
	int          comparisons = 0;
	int          n_abort = 0;
	int          cycles = 0;
	int          r;
	int          c;
	// register rows: address, written value, value read back
	logic [7:0]  ra [5] = '{8'h00, 8'h00, 8'h10, 8'h1c, 8'h04};
	logic [15:0] rw [5] = '{16'hfffe, 16'h0200, 16'hfffe, 16'hbeef, 16'hffff};
	logic [15:0] rx [5] = '{16'h0300, 16'h0200, 16'h0f5c, 16'hbeef, 16'h0000};
	// priority runs: mode, count per channel, grant order two bits a unit
	logic [1:0]  pt [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
	logic [15:0] ct [4] = '{16'h0002, 16'h0001, 16'h0001, 16'h0001};
	logic [15:0] ot [4] = '{16'h1b1b, 16'h001b, 16'h002d, 16'h0087};
	always #2 clk = ~clk;
	dmacm_top uut (.clk, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata, .nmi_event,
		.addr_error_event, .external_request_in_n, .receive_full_request(2'h0),
		.transmit_empty_request(2'h0), .conversion_end_request(conv_req),
		.compare_match_request(1'b0), .xfer_valid, .xfer_chan, .xfer_size(),
		.xfer_source, .xfer_done, .xfer_abort, .external_ack_out, .transfer_end_interrupt);
	dmacm_bus_model partner (.clk, .xfer_valid, .wait_cycles, .xfer_done);
	task automatic finish_test;
		if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// writes leave an idle edge after them so no strobe is set twice in one step
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
		@(posedge clk);
	endtask
	task automatic wait_irq(input logic [3:0] irq);
		for (int i = 0; i < 300 && transfer_end_interrupt !== irq; i++) @(posedge clk);
		check({12'h000, transfer_end_interrupt}, {12'h000, irq});
	endtask
	task automatic wait_valid;
		for (int i = 0; i < 100 && xfer_valid !== 1'b1; i++) @(posedge clk);
		check({15'h0000, xfer_valid}, 16'h0001);
	endtask
	task automatic pulse_event(input logic is_nmi);
		nmi_event <= is_nmi;
		addr_error_event <= !is_nmi;
		@(posedge clk);
		nmi_event <= 1'b0;
		addr_error_event <= 1'b0;
	endtask
	// unit grant log, abort count and hang guard
	always @(posedge clk) begin
		prev_valid <= xfer_valid;
		if (xfer_valid && !prev_valid) order <= {order[13:0], xfer_chan};
		if (xfer_abort) n_abort++;
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
		rd_chk(8'h00, 16'h0000);
		rd_chk(8'h24, 16'h0000);
		for (r = 0; r < 5; r++) begin
			wr_reg(ra[r], rw[r]);
			rd_chk(ra[r], rx[r]);
		end
		// all four channels auto, prompt and slow far side
		for (r = 0; r < 4; r++) begin
			wait_cycles <= 4'(r * 3);
			wr_reg(8'h00, 16'h0000);
			for (c = 0; c < 4; c++) begin
				rd_chk(8'(16 + c * 8), r ? 16'h0407 : c ? 16'h0000 : 16'h0f5c);
				wr_reg(8'(20 + c * 8), ct[r]);
				wr_reg(8'(16 + c * 8), 16'h0405);
			end
			wr_reg(8'h00, {6'h00, pt[r], 8'h01});
			wait_irq(4'hf);
			// the log keeps older grants; fixed runs have four units, so only the low byte is new
			check((r == 0) ? order : {8'h00, order[7:0]}, ot[r]);
		end
		// a slow unit hit by nmi, address error and master disable in turn
		wait_cycles <= 4'h8;
		wr_reg(8'h00, 16'h0000);
		rd_chk(8'h10, 16'h0407);
		wr_reg(8'h14, 16'h0003);
		wr_reg(8'h10, 16'h0405);
		// the interrupt line trails the flag clear by one registered stage
		@(posedge clk);
		check({12'h000, transfer_end_interrupt}, 16'h000e);
		wr_reg(8'h00, 16'h0001);
		wait_valid();
		pulse_event(1'b1);
		rd_chk(8'h00, 16'h0003);
		wr_reg(8'h00, 16'h0003);
		rd_chk(8'h00, 16'h0003);
		wr_reg(8'h00, 16'h0001);
		wait_valid();
		pulse_event(1'b0);
		wr_reg(8'h00, 16'h0001);
		rd_chk(8'h00, 16'h0005);
		wr_reg(8'h00, 16'h0001);
		wait_valid();
		wr_reg(8'h00, 16'h0000);
		// the abort pulse lands one edge after the disable is taken and is counted on the edge after that
		repeat (2) @(posedge clk);
		check(16'(n_abort), 16'h0003);
		rd_chk(8'h14, 16'h0003);
		rd_chk(8'h10, 16'h0405);
		// edge request on channel 0 held low gives one unit only
		wait_cycles <= 4'h0;
		wr_reg(8'h14, 16'h0002);
		wr_reg(8'h10, 16'h0245);
		external_request_in_n <= 2'h2;
		wr_reg(8'h00, 16'h0001);
		wait_valid();
		check({14'h0000, external_ack_out}, 16'h0001);
		repeat (30) @(posedge clk);
		rd_chk(8'h14, 16'h0001);
		external_request_in_n <= 2'h3;
		@(posedge clk);
		external_request_in_n <= 2'h2;
		wait_irq(4'hf);
		// level request on channel 1, dual mode, runs to its count
		rd_chk(8'h18, 16'h0407);
		wr_reg(8'h1c, 16'h0002);
		wr_reg(8'h18, 16'h0005);
		external_request_in_n <= 2'h0;
		wait_valid();
		check({14'h0000, external_ack_out}, 16'h0002);
		wait_irq(4'hf);
		rd_chk(8'h1c, 16'h0000);
		// converter request on channel 2: blocked at 16-byte size, served at byte size
		rd_chk(8'h20, 16'h0407);
		wr_reg(8'h24, 16'h0001);
		conv_req <= 1'b1;
		wr_reg(8'h20, 16'h0e1d);
		repeat (10) @(posedge clk);
		rd_chk(8'h24, 16'h0001);
		wr_reg(8'h20, 16'h0e05);
		wait_valid();
		check({12'h000, xfer_source}, 16'h000e);
		wait_irq(4'hf);
		conv_req <= 1'b0;
		external_request_in_n <= 2'h3;
		// standby: a write while the clock enable is low must not land
		ce <= 1'b0;
		wr_reg(8'h00, 16'h0200);
		ce <= 1'b1;
		rd_chk(8'h00, 16'h0001);
		// nmi while idle still raises the flag; a mid-run reset clears it
		pulse_event(1'b1);
		rd_chk(8'h00, 16'h0003);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(8'h00, 16'h0000);
		finish_test();
	end
endmodule // tb_dma_channel_master_control
`default_nettype wire
